// [rtl/tbop_port.v]
// Two-bit output-only port with per-pin drive modes behind an APB slave
// Behaviour
// - Two pins, both output only; pin levels never reach the data register
// - Data bit 0 drives pin zero, bit 1 pin one; 0 low, 1 high
// - Data register reads back the written value, not the pin level
// - Control bit pair per pin: 00 hi-z, 01 P open drain, 10 N open drain, 11 CMOS
// - Reset clears data and both control registers, all pins hi-z
// - Each pin's drive mode is chosen independently
// - Control registers accessible as bytes or as one 16-bit word, low byte first
`timescale 1ns/1ps
`include "tbop_regs.vh"
module tbop_port (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  output reg [1:0] out_pin_o,
  output reg [1:0] out_pin_oe
);
  // Register state
  reg [1:0] pin_level_out_q;
  reg [1:0] pin_level_out_d;
  reg [1:0] drive_mode_low_q;
  reg [1:0] drive_mode_low_d;
  reg [1:0] drive_mode_high_q;
  reg [1:0] drive_mode_high_d;

  // Next values of the registered outputs
  reg [31:0] prdata_d;
  reg pready_d;
  reg pslverr_d;
  reg [1:0] pin_o_d;
  reg [1:0] pin_oe_d;
  reg [31:0] rdata_d;

  // Byte address of a register index
  function [`TBOP_ADDR_W-1:0] byte_addr;
    input [15:0] idx;
    begin
      byte_addr = {idx, 2'h0};
    end
  endfunction

  // Address match against one register index
  function addr_is;
    input [`TBOP_ADDR_W-1:0] adr;
    input [15:0] idx;
    begin
      addr_is = (adr == byte_addr(idx));
    end
  endfunction

  // Output enable of one pin for its mode pair and level
  function pin_enable;
    input [1:0] md;
    input lvl;
    begin
      case (md)
        `TBOP_MODE_PCH_OD: pin_enable = lvl;
        `TBOP_MODE_NCH_OD: pin_enable = ~lvl;
        `TBOP_MODE_CMOS: pin_enable = 1'b1;
        default: pin_enable = 1'b0;
      endcase
    end
  endfunction

  // Bus phases; writes commit only at the edge that completes the access
  wire setup = psel && !penable;
  wire acc_ok = psel && penable && pready;
  wire wr_ok = acc_ok && pwrite && pstrb[0];
  wire [`TBOP_ADDR_W-1:0] a = paddr[`TBOP_ADDR_W-1:0];
  wire addr_hi_zero = (paddr[31:`TBOP_ADDR_W] == 14'h0);

  // Register selects
  wire sel_data = addr_hi_zero && addr_is(a, `TBOP_IDX_PIN_LEVEL_OUT);
  wire sel_low = addr_hi_zero && addr_is(a, `TBOP_IDX_DRIVE_MODE_LOW);
  wire sel_high = addr_hi_zero && addr_is(a, `TBOP_IDX_DRIVE_MODE_HIGH);
  wire sel_word = addr_hi_zero && addr_is(a, `TBOP_IDX_DRIVE_MODE_WORD);
  wire hit_any = sel_data || sel_low || sel_high || sel_word;

  // Write strobes per register
  wire wr_data = wr_ok && sel_data;
  wire wr_low = wr_ok && (sel_low || sel_word);
  wire wr_high = wr_ok && sel_high;
  wire wr_word_hi = wr_ok && sel_word && pstrb[1];

  // Read views, upper bits read zero
  wire [31:0] rd_data = {30'h0, pin_level_out_q};
  wire [31:0] rd_low = {30'h0, drive_mode_low_q};
  wire [31:0] rd_high = {30'h0, drive_mode_high_q};
  wire [31:0] rd_word = {22'h0, drive_mode_high_q, 6'h0, drive_mode_low_q};

  // Per-pin mode pairs, chosen independently
  wire [1:0] pin0_mode = {drive_mode_high_q[0], drive_mode_low_q[0]};
  wire [1:0] pin1_mode = {drive_mode_high_q[1], drive_mode_low_q[1]};

  // Read mux, no pin input path
  always @* begin
    rdata_d = 32'h0;
    if (sel_data) begin
      rdata_d = rd_data;
    end else if (sel_low) begin
      rdata_d = rd_low;
    end else if (sel_high) begin
      rdata_d = rd_high;
    end else if (sel_word) begin
      rdata_d = rd_word;
    end
  end

  // Ready for exactly one access cycle after each setup
  always @* begin
    pready_d = setup;
  end

  // Error for an unmapped address
  always @* begin
    pslverr_d = 1'b0;
    if (setup) begin
      pslverr_d = !hit_any;
    end
  end

  // Read data stands only while ready is high
  always @* begin
    prdata_d = 32'h0;
    if (setup && !pwrite) begin
      prdata_d = rdata_d;
    end
  end

  // Data register next value
  always @* begin
    pin_level_out_d = pin_level_out_q;
    if (wr_data) begin
      pin_level_out_d = pwdata[1:0];
    end
  end

  // Low control register, byte or word view
  always @* begin
    drive_mode_low_d = drive_mode_low_q;
    if (wr_low) begin
      drive_mode_low_d = pwdata[1:0];
    end
  end

  // High control register, byte or upper word lane
  always @* begin
    drive_mode_high_d = drive_mode_high_q;
    if (wr_high) begin
      drive_mode_high_d = pwdata[1:0];
    end else if (wr_word_hi) begin
      drive_mode_high_d = pwdata[9:8];
    end
  end

  // Pin drivers
  always @* begin
    pin_o_d = pin_level_out_q;
    pin_oe_d[0] = pin_enable(pin0_mode, pin_level_out_q[0]);
    pin_oe_d[1] = pin_enable(pin1_mode, pin_level_out_q[1]);
  end

  // Data register
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_level_out_q <= `TBOP_RESET_VAL;
    end else begin
      pin_level_out_q <= pin_level_out_d;
    end
  end

  // Low control register
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drive_mode_low_q <= `TBOP_RESET_VAL;
    end else begin
      drive_mode_low_q <= drive_mode_low_d;
    end
  end

  // High control register
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drive_mode_high_q <= `TBOP_RESET_VAL;
    end else begin
      drive_mode_high_q <= drive_mode_high_d;
    end
  end

  // Bus answer flops
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      prdata <= prdata_d;
      pready <= pready_d;
      pslverr <= pslverr_d;
    end
  end

  // Pin level flops
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_pin_o <= 2'h0;
    end else begin
      out_pin_o <= pin_o_d;
    end
  end

  // Pin enable flops, all pins float under reset
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_pin_oe <= 2'h0;
    end else begin
      out_pin_oe <= pin_oe_d;
    end
  end
endmodule // tbop_port

// [rtl/tbop_regs.vh]
// Register map and field constants of the two-bit output port
`ifndef TBOP_REGS_VH
`define TBOP_REGS_VH
// Printed offsets are not all multiples of four: each is a register index
`define TBOP_IDX_PIN_LEVEL_OUT 16'hf248
`define TBOP_IDX_DRIVE_MODE_LOW 16'hf24a
`define TBOP_IDX_DRIVE_MODE_HIGH 16'hf24b
// Word view of both mode registers, low byte in [7:0]
`define TBOP_IDX_DRIVE_MODE_WORD 16'hf24c
`define TBOP_ADDR_W 18
`define TBOP_RESET_VAL 2'h0
`define TBOP_MODE_HIZ 2'h0
`define TBOP_MODE_PCH_OD 2'h1
`define TBOP_MODE_NCH_OD 2'h2
`define TBOP_MODE_CMOS 2'h3
`endif

// [dv/tbop_props.sv]
// Checker of APB answers and pin drive
`timescale 1ns/1ps
module tbop_props(input wire pclk, presetn, psel, penable, pwrite, pready, pslverr,
  input wire [31:0] paddr, pwdata, prdata, input wire [3:0] pstrb,
  input wire [1:0] out_pin_o, out_pin_oe);
  wire su = psel & ~penable;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_once: assert property (su |=> pready ##1 !pready) else $error("rdy");
  a_ready_cause: assert property (pready |-> $past(su)) else $error("rdy2");
  a_err_ready: assert property (pslverr |-> pready) else $error("err");
  a_rdata_idle: assert property (!pready |-> !prdata) else $error("rd");
  a_rdata_bits: assert property (!prdata[31:10] && !prdata[7:2]) else $error("msb");
  a_pin_src: assert property ($changed(out_pin_o) |-> $past(psel&penable&pready&pwrite,2)) else $error("p");
  a_oe_src: assert property ($changed(out_pin_oe) |-> $past(psel&penable&pready&pwrite,2)) else $error("o");
  a_reset_hiz: assert property (disable iff (0) !presetn |-> !out_pin_oe) else $error("z");
endmodule // tbop_props
bind tbop_port tbop_props tbop_props_i(.*);

// [dv/tbop_lamps.sv]
// Lamps hung from the pins through a pull-up
`timescale 1ns/1ps
module tbop_lamps(input wire [1:0] out_pin_o, out_pin_oe, output wire [1:0] pin_level);
  assign pin_level = (out_pin_o & out_pin_oe) | ~out_pin_oe;
endmodule // tbop_lamps

// [dv/tb_top.sv]
// Random bench of the two-bit output port
`timescale 1ns/1ps
module tb_top;
  logic pclk = 0, presetn = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, er;
  logic [31:0] paddr = 0, pwdata = 0, prdata, v, rd, e[4];
  logic [31:0] adr[4] = '{32'h3c920, 32'h3c928, 32'h3c92c, 32'h3c930};
  logic [3:0] pstrb = 0;
  logic [1:0] out_pin_o, out_pin_oe, lvl, d, lo, hi;
  int n_fail = 0, comparisons = 0, k;
  always #2.5 pclk = ~pclk;
  tbop_port tbop_port_i(.*);
  tbop_lamps tbop_lamps_i(.pin_level(lvl), .*);
  task complete_run;
    if (n_fail == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task cmp(input logic [31:0] g, x);
    comparisons++;
    if (g !== x) begin
      n_fail++;
      $display("wrong value %0t %h/%h", $time, g, x);
    end
  endtask
  function logic [1:0] want(input logic [1:0] d, lo, hi);
    for (int j = 0; j < 2; j++)
      want[j] = ({hi[j], lo[j]} == 2'h3 || {hi[j], lo[j]} == {~d[j], d[j]}) ? d[j] : 1'b1;
  endfunction
  task apb(input logic w, input logic [31:0] a, input logic [3:0] s);
    {psel, penable, pwrite, paddr, pwdata, pstrb} <= {2'b10, w, a, v, s};
    @(posedge pclk) penable <= 1;
    k = 0;
    do @(posedge pclk); while (pready !== 1 && ++k < 9);
    {rd, er} = {prdata, pslverr};
    {psel, penable} <= 2'b00;
    if (k == 9) begin
      n_fail++;
      complete_run;
    end
    @(posedge pclk);
  endtask
  initial begin
    v = $urandom(32'h490ba0a8);
    repeat (2) begin
      presetn <= 0;
      repeat (20) @(posedge pclk);
      presetn <= 1;
      {d, lo, hi} = 0;
      repeat (40) begin
        e = '{{30'h0, d}, {30'h0, lo}, {30'h0, hi}, {22'h0, hi, 6'h0, lo}};
        foreach (adr[i]) begin
          apb(0, adr[i], 0);
          cmp(rd, e[i]);
        end
        cmp(lvl, want(d, lo, hi));
        v = $urandom;
        apb(1, adr[v[4:3]], {2'h0, v[5] & v[2], v[2]});
        if (v[2] && v[4:3] == 0) d = v[1:0];
        if (v[2] && v[3]) lo = v[1:0];
        if (v[2] && v[4:3] == 2) hi = v[1:0];
        if (v[2] && v[5] && v[4:3] == 3) hi = v[9:8];
      end
      apb(0, 32'h3c924, 0);
      cmp(er, 1);
    end
    complete_run;
  end
endmodule // tb_top
